/* File: hw/gat_device.sv */
// Purpose: device end: command decode, addressed state, end detection
// Assumes: controller keeps its own rules; link inputs synchronous to hclk
// Notes:   one byte per cycle of dav high with acc from the listener
`default_nettype none
// Function
// [RULE_01] unique primary address within 0 to 30
// [RULE_02] bits 4:0 address, 5 listen, 6 talk
// [RULE_03] bit 7 ignored in command decode
// [RULE_04] listen code is address plus 20h
// [RULE_05] talk code is address plus 40h
// [RULE_06] secondary code is value plus 60h
// [RULE_07] secondary must immediately follow primary code
// [RULE_08] untalk 5Fh drops talker state
// [RULE_09] other talk address drops talker state
// [RULE_10] unlisten 3Fh drops every listener
// [RULE_11] end detection only on data bytes
// [RULE_12] end character match finishes the read
// [RULE_13] talker asserts end line with last byte
// [RULE_14] listener ends read on end line
// [RULE_15] count reached stops accepting, holds talker off
// [RULE_16] unsent talker data stays pending
// [RULE_17] termination conditions are ORed together
// [RULE_18] talker sends end character with end line
// [RULE_19] data sourced only while talker addressed
// [RULE_20] controller addresses talker and listener first
// [RULE_21] service request independent of other state
// [RULE_22] attention high means command, else data
// [RULE_23] address 31 rejected as configuration
module gat_device (
  input  wire logic       hclk,        // system clock
  input  wire logic       hresetn,     // async reset, active low
  gat_link_if.dev         link,        // bus side
  input  wire logic [4:0] my_addr,     // configured primary address
  input  wire logic       sec_en,      // device uses a secondary address
  input  wire logic [4:0] my_sec,      // configured secondary address
  input  wire logic       term_char,   // end character method
  input  wire logic       term_line,   // end line method
  input  wire logic       term_count,  // count method
  input  wire logic [7:0] end_char,    // end character
  input  wire logic [15:0] read_count, // bytes per read
  input  wire logic       read_start,  // pulse: begin a read
  input  wire logic [7:0] tx_byte,     // pending byte to send
  input  wire logic       tx_valid,    // pending byte present
  input  wire logic       tx_last,     // pending byte is last
  input  wire logic       srq_req,     // ask for service
  output logic            tx_taken,    // pulse: pending byte sent
  output logic [7:0]      rx_byte,     // last received data byte
  output logic            rx_strobe,   // pulse: data byte received
  output logic            read_done,   // pulse: read finished
  output logic            talker,      // talker addressed
  output logic            listener,    // listener addressed
  output logic            addr_bad     // configured address illegal
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_WAIT_SEC = 3'b010, ST_XFER = 3'b100
  } gat_dstate_type;

  typedef struct packed {
    gat_dstate_type st;
    logic           pend_talk;
    logic           pend_listen;
    logic           talker;
    logic           listener;
    logic           reading;
    logic [15:0]    count;
    logic [7:0]     rx_byte;
    logic           rx_strobe;
    logic           read_done;
    logic           tx_taken;
    logic           dav_out;
    logic           acc_out;
    logic           addr_bad;
    logic [7:0]     dio_out;
    logic           eoi_out;
  } gat_dev_type;

  gat_dev_type r;
  gat_dev_type next_r;
  logic [7:0]  code;
  logic        got;
  logic        srq_r;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_r           = r;
    next_r.rx_strobe = 1'b0;
    next_r.read_done = 1'b0;
    next_r.tx_taken  = 1'b0;
    next_r.acc_out   = 1'b0;
    code             = {1'b0, link.dio[6:0]};             // [RULE_03]
    got              = link.dav & ~r.acc_out & ~r.dav_out;
    next_r.addr_bad  = (my_addr > gat_pkg::ADDR_MAX);     // [RULE_23] [RULE_01]
    if (link.atn) begin
      next_r.dav_out = 1'b0;                              // command phase frees data
      if (got) begin                                      // [RULE_22]
        next_r.acc_out = 1'b1;
        // a pending primary is dropped by any command byte that is not its secondary
        next_r.st = ST_IDLE;
        if (r.st == ST_WAIT_SEC && code[6:5] == gat_pkg::GRP_SECOND &&
            code[4:0] == my_sec) begin                    // [RULE_06] [RULE_07]
          if (r.pend_talk)   next_r.talker   = 1'b1;
          if (r.pend_listen) next_r.listener = 1'b1;
        end
        next_r.pend_talk   = 1'b0;
        next_r.pend_listen = 1'b0;
        if (code[6:0] == gat_pkg::CMD_UNL) begin
          next_r.listener = 1'b0;                         // [RULE_10]
        end else if (code[6:0] == gat_pkg::CMD_UNT) begin
          next_r.talker = 1'b0;                           // [RULE_08]
        end else if (gat_pkg::gat_is_addr(code, gat_pkg::GRP_LISTEN) &&
                     code[4:0] == my_addr && !r.addr_bad) begin // [RULE_02] [RULE_04]
          if (sec_en) begin
            next_r.pend_listen = 1'b1;
            next_r.st          = ST_WAIT_SEC;
          end else begin
            next_r.listener = 1'b1;
          end
        end else if (gat_pkg::gat_is_addr(code, gat_pkg::GRP_TALK)) begin // [RULE_05]
          if (code[4:0] == my_addr && !r.addr_bad) begin
            if (sec_en) begin
              next_r.pend_talk = 1'b1;
              next_r.st        = ST_WAIT_SEC;
              next_r.talker    = 1'b0;
            end else begin
              next_r.talker = 1'b1;
            end
          end else begin
            next_r.talker = 1'b0;                         // [RULE_09]
          end
        end
      end
    end else begin
      if (read_start && r.listener) begin
        next_r.reading = 1'b1;
        next_r.count   = gat_pkg::CNT_RST;
      end
      // listener side: accept while a read runs and count not reached
      if (got && r.listener && r.reading) begin           // [RULE_11]
        next_r.acc_out   = 1'b1;
        next_r.rx_byte   = link.dio;
        next_r.rx_strobe = 1'b1;
        next_r.count     = r.count + 16'h0001;
        if ((term_char && link.dio == end_char) ||        // [RULE_12]
            (term_line && link.eoi) ||                    // [RULE_14]
            (term_count && (r.count + 16'h0001) >= read_count)) begin // [RULE_17] [RULE_15]
          next_r.reading   = 1'b0;
          next_r.read_done = 1'b1;
        end
      end
      // talker side: put pending byte up, drop it once accepted
      if (r.dav_out) begin
        if (link.acc_ctl) begin
          next_r.dav_out  = 1'b0;
          next_r.tx_taken = 1'b1;                         // [RULE_16]
        end
      end else if (r.talker && tx_valid && !r.tx_taken) begin // [RULE_19]
        next_r.dav_out = 1'b1;
        next_r.dio_out = tx_byte;
        // last byte, or end character when both methods on
        next_r.eoi_out = term_line && (tx_last ||
                         (term_char && tx_byte == end_char)); // [RULE_13] [RULE_18]
      end
    end
    next_r.st = (next_r.st == ST_WAIT_SEC) ? ST_WAIT_SEC : ST_IDLE;
    if (!r.talker) next_r.dav_out = next_r.dav_out & next_r.talker;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r    <= '0;
      r.st <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; count hold-off shows while a listener is not reading
  assign link.dio_dev    = r.dio_out;
  assign link.dio_dev_oe = r.dav_out;                     // [RULE_19]
  assign link.dav_dev    = r.dav_out;
  assign link.eoi_dev    = r.eoi_out & r.dav_out;
  assign link.acc_dev    = r.acc_out;
  assign link.hold_dev   = r.listener & ~r.reading;       // [RULE_15]
  assign link.srq        = srq_r;                         // [RULE_21]
  assign tx_taken        = r.tx_taken;
  assign rx_byte         = r.rx_byte;
  assign rx_strobe       = r.rx_strobe;
  assign read_done       = r.read_done;
  assign talker          = r.talker;
  assign listener        = r.listener;
  assign addr_bad        = r.addr_bad;

  // service request kept apart from all addressing state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) srq_r <= 1'b0;
    else          srq_r <= srq_req;                       // [RULE_21]
  end
endmodule : gat_device
`default_nettype wire

/* File: hw/gat_pkg.sv */
// Purpose: shared constants and a decode function for the addressing and termination link
// Assumes: one clock hclk, async active-low reset hresetn
// Notes:   command codes and field positions used by the device end, register offsets by the controller end
`default_nettype none
package gat_pkg;
  localparam int unsigned   PA_LSB      = 0;       // primary address field low bit
  localparam int unsigned   PA_MSB      = 4;       // primary address field high bit
  localparam int unsigned   LA_BIT      = 5;       // listen flag
  localparam int unsigned   TA_BIT      = 6;       // talk flag
  localparam logic [4:0]    ADDR_MAX    = 5'h1e;   // highest legal address
  localparam logic [4:0]    ADDR_RST    = 5'h00;   // reset address
  localparam logic [6:0]    CMD_UNL     = 7'h3f;   // unlisten
  localparam logic [6:0]    CMD_UNT     = 7'h5f;   // untalk
  localparam logic [1:0]    GRP_LISTEN  = 2'h1;    // bits 6:5 of listen code
  localparam logic [1:0]    GRP_TALK    = 2'h2;    // bits 6:5 of talk code
  localparam logic [1:0]    GRP_SECOND  = 2'h3;    // bits 6:5 of secondary code
  localparam logic [15:0]   CNT_RST     = 16'h0000;
  localparam logic [7:0]    BYTE_RST    = 8'h00;
  // register offsets of the controller end (AHB-Lite word addresses)
  localparam logic [7:0]    OFF_CTRL    = 8'h00;   // go bits and attention
  localparam logic [7:0]    OFF_TXBYTE  = 8'h04;   // byte to send
  localparam logic [7:0]    OFF_STATUS  = 8'h08;   // busy, last byte received
  localparam logic [7:0]    OFF_SRQ     = 8'h0c;   // service request seen

  // returns 1 when code is a legal primary address command of group grp
  function automatic logic gat_is_addr(input logic [7:0] code, input logic [1:0] grp);
    return (code[TA_BIT:LA_BIT] == grp) && (code[PA_MSB:PA_LSB] <= ADDR_MAX);
  endfunction : gat_is_addr
endpackage : gat_pkg
`default_nettype wire

/* File: hw/gat_link_if.sv */
// Purpose: bus wires between controller and device
// Assumes: open-collector lines resolved here from enables
// Notes:   byte handshake is a simplified valid/accept pair
`default_nettype none
interface gat_link_if;
  logic [7:0] dio_ctl;     // controller data out
  logic       dio_ctl_oe;  // controller drives data
  logic [7:0] dio_dev;     // device data out
  logic       dio_dev_oe;  // device drives data
  logic       atn;         // attention, from controller
  logic       dav_ctl;     // controller byte valid
  logic       dav_dev;     // device byte valid
  logic       eoi_ctl;     // controller end marker
  logic       eoi_dev;     // device end marker
  logic       acc_ctl;     // controller accepts byte
  logic       acc_dev;     // device accepts byte
  logic       hold_dev;    // device holds off talker
  logic       srq;         // service request, from device
  logic [7:0] dio;         // resolved data lines
  logic       dav;         // resolved valid
  logic       eoi;         // resolved end marker
  assign dio = dio_ctl_oe ? dio_ctl : (dio_dev_oe ? dio_dev : 8'hff);
  assign dav = dav_ctl | dav_dev;
  assign eoi = eoi_ctl | eoi_dev;
  modport ctl (output dio_ctl, dio_ctl_oe, atn, dav_ctl, eoi_ctl, acc_ctl,
               input dio, dav, eoi, acc_dev, hold_dev, srq);
  modport dev (output dio_dev, dio_dev_oe, dav_dev, eoi_dev, acc_dev, hold_dev, srq,
               input dio, dav, eoi, atn, acc_ctl);
endinterface : gat_link_if
`default_nettype wire

/* File: hw/gat_controller.sv */
// Purpose: controller end: sends commands and data bytes from AHB-Lite orders
// Assumes: single-word AHB-Lite transfers, always OKAY
// Notes:   one byte per order; zero wait states on the bus
`default_nettype none
module gat_controller (
  input  wire logic        hclk,       // system clock
  input  wire logic        hresetn,    // async reset, active low
  gat_link_if.ctl          link,       // bus side
  input  wire logic        hsel,       // slave select
  input  wire logic [31:0] haddr,      // address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write
  input  wire logic [2:0]  hsize,      // size, word only
  input  wire logic [31:0] hwdata,     // write data
  input  wire logic        hready,     // bus ready
  output logic [31:0]      hrdata,     // read data
  output logic             hreadyout,  // slave ready
  output logic             hresp       // response, always OKAY
);
  typedef struct packed {
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       atn;
    logic       eoi;
    logic       send;
    logic       busy;
    logic [7:0] tx;
    logic [7:0] rx;
    logic       rx_new;
    logic       accept;
    logic       acc;
    logic [31:0] rdata;
  } gat_ctl_type;

  gat_ctl_type r;
  gat_ctl_type next_r;
  logic        phase;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave and byte sender; controller addresses before data [RULE_20]
  always_comb begin
    next_r         = r;
    next_r.acc     = 1'b0;
    phase          = hsel & htrans[1] & hready;
    next_r.wr_pend = phase & hwrite;
    if (phase) next_r.wr_addr = haddr[7:0];
    if (phase && !hwrite) begin
      unique case (haddr[7:0])
        gat_pkg::OFF_CTRL:   next_r.rdata = {28'h0, r.accept, r.eoi, r.atn, r.send};
        gat_pkg::OFF_TXBYTE: next_r.rdata = {24'h0, r.tx};
        gat_pkg::OFF_STATUS: next_r.rdata = {22'h0, r.rx_new, r.busy, r.rx};
        gat_pkg::OFF_SRQ:    next_r.rdata = {31'h0, link.srq};
        default:             next_r.rdata = 32'h0;
      endcase
      if (haddr[7:0] == gat_pkg::OFF_STATUS) next_r.rx_new = 1'b0;
    end
    if (r.wr_pend) begin
      unique case (r.wr_addr)
        gat_pkg::OFF_CTRL: begin
          next_r.atn    = hwdata[1];
          next_r.eoi    = hwdata[2];
          next_r.accept = hwdata[3];
          if (hwdata[0] && !r.busy) next_r.busy = 1'b1;
        end
        gat_pkg::OFF_TXBYTE: next_r.tx = hwdata[7:0];
        default: ;
      endcase
    end
    // byte out: valid until device accepts; hold-off stalls data only, commands pass
    if (r.busy && !r.send && (r.atn || !link.hold_dev)) next_r.send = 1'b1; // [RULE_15]
    if (r.send && link.acc_dev) begin
      next_r.send = 1'b0;
      next_r.busy = 1'b0;
    end
    // byte in from the talker, set wins over clear
    if (r.accept && !r.atn && link.dav && !r.send && !r.acc) begin
      next_r.acc    = 1'b1;
      next_r.rx     = link.dio;
      next_r.rx_new = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) r <= '0;
    else          r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign link.dio_ctl    = r.tx;
  assign link.dio_ctl_oe = r.send;
  assign link.atn        = r.atn;
  assign link.dav_ctl    = r.send;
  assign link.eoi_ctl    = r.send & r.eoi;
  assign link.acc_ctl    = r.acc;
  assign hrdata          = r.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
endmodule : gat_controller
`default_nettype wire

/* File: testbench/gat_link_properties.sv */
// Purpose: link-level checks between controller end and device end
// Assumes: one clock hclk, async active-low reset hresetn
// Notes:   sees only the interface wires, no design internals
`default_nettype none
module gat_link_properties (
  input wire logic       hclk,        // system clock
  input wire logic       hresetn,     // async reset, active low
  input wire logic       atn,         // attention from controller
  input wire logic       dav,         // resolved byte valid
  input wire logic       dav_dev,     // device byte valid
  input wire logic       dio_dev_oe,  // device drives data
  input wire logic [7:0] dio_dev,     // device data out
  input wire logic       eoi_dev,     // device end marker
  input wire logic       acc_ctl,     // controller accepts byte
  input wire logic       acc_dev,     // device accepts byte
  input wire logic       hold_dev,    // device holds talker off
  input wire logic       srq          // service request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////////////////
  // command bytes are always taken, one cycle after valid rises
  AST_CMD_ACCEPTED:
    assert property ($rose(dav) && atn |=> acc_dev)
      else $error("command byte not accepted");
  // an accept pulse only answers a byte that stands on the lines
  AST_ACC_AFTER_DAV:
    assert property ($rose(acc_dev) |-> $past(dav) && dav)
      else $error("device accept without valid byte");
  // device valid never without driving the data lines
  AST_DAV_NEEDS_DRIVE:
    assert property (dav_dev |-> dio_dev_oe)
      else $error("device valid without data drive");
  // one cycle of grace after attention rises, then the device is silent
  AST_QUIET_UNDER_ATN:
    assert property (atn && $past(atn) |-> !dav_dev)
      else $error("device sends during attention");
  // byte and data held until the controller accepts
  AST_DAV_HELD:
    assert property (dav_dev && !acc_ctl |=> dav_dev && $stable(dio_dev))
      else $error("device byte dropped before accept");
  AST_DAV_RELEASE:
    assert property (acc_ctl && dav_dev |=> !dav_dev)
      else $error("device valid kept after accept");
  // end marker travels with a byte, never alone
  AST_EOI_WITH_BYTE:
    assert property (eoi_dev |-> dav_dev)
      else $error("end marker without byte");
  // a finished count refuses further data bytes
  AST_HOLD_REFUSES:
    assert property (hold_dev && !atn && $rose(dav) |=> !acc_dev)
      else $error("data accepted while holding off");
  //////////////////////////////////////////////////////////////////////////////
  // main scenarios reached
  cover property ($rose(dav) && atn);
  cover property ($rose(dav_dev));
  cover property ($rose(hold_dev));
  cover property ($rose(srq));
endmodule : gat_link_properties
`default_nettype wire

/* File: testbench/ieee488_addr_term_logic_tb.sv */
// Purpose: self-checking bench for controller and device joined by the link
// Assumes: controller registers reached over single-word zero-wait transfers
// Notes:   device configured at address 5 unless a test changes it
`default_nettype none
module ieee488_addr_term_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [4:0]  my_addr, my_sec;
  logic        sec_en, term_char, term_line, term_count, read_start;
  logic [7:0]  end_char, tx_byte, rx_byte;
  logic [15:0] read_count;
  logic        tx_valid, tx_last, srq_req, tx_taken, rx_strobe, read_done;
  logic        talker, listener, addr_bad;
  int          num_errors, num_checks, cycles, done_cnt, strobe_cnt, taken_cnt, eoi_cnt;
  assign hready = hreadyout;
  //////////////////////////////////////////////////////////////////////////////
  gat_link_if gat_link_if_inst ();
  gat_controller gat_controller_inst (.hclk(hclk), .hresetn(hresetn), .link(gat_link_if_inst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  gat_device gat_device_inst (.hclk(hclk), .hresetn(hresetn), .link(gat_link_if_inst),
    .my_addr(my_addr), .sec_en(sec_en), .my_sec(my_sec), .term_char(term_char),
    .term_line(term_line), .term_count(term_count), .end_char(end_char),
    .read_count(read_count), .read_start(read_start), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_last(tx_last), .srq_req(srq_req), .tx_taken(tx_taken), .rx_byte(rx_byte),
    .rx_strobe(rx_strobe), .read_done(read_done), .talker(talker), .listener(listener),
    .addr_bad(addr_bad));
  gat_link_properties gat_link_properties_inst (.hclk(hclk), .hresetn(hresetn),
    .atn(gat_link_if_inst.atn), .dav(gat_link_if_inst.dav),
    .dav_dev(gat_link_if_inst.dav_dev), .dio_dev_oe(gat_link_if_inst.dio_dev_oe),
    .dio_dev(gat_link_if_inst.dio_dev), .eoi_dev(gat_link_if_inst.eoi_dev),
    .acc_ctl(gat_link_if_inst.acc_ctl), .acc_dev(gat_link_if_inst.acc_dev),
    .hold_dev(gat_link_if_inst.hold_dev), .srq(gat_link_if_inst.srq));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // pulse counters, plus a cycle ceiling so a stuck handshake cannot hang the run
  always @(posedge hclk) begin
    cycles++;
    if (read_done === 1'b1) done_cnt++;
    if (rx_strobe === 1'b1) strobe_cnt++;
    if (tx_taken === 1'b1) taken_cnt++;
    if (gat_link_if_inst.eoi_dev === 1'b1) eoi_cnt++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one transfer: address phase held to hready, then data phase held to hready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask : rd_chk
  // c: bit0 send, bit1 attention, bit2 end marker; waits for busy to clear
  task automatic xfer(input logic [7:0] b, input logic [2:0] c);
    logic [31:0] r;
    wr(gat_pkg::OFF_TXBYTE, {24'h0, b});
    wr(gat_pkg::OFF_CTRL, {29'h0, c});
    do ahb(1'b0, gat_pkg::OFF_STATUS, 32'h0, r); while (r[8] !== 1'b0);
    repeat (2) @(posedge hclk);
  endtask : xfer
  task automatic st(input logic t, input logic l);
    chk({30'h0, talker, listener}, {30'h0, t, l});
  endtask : st
  // attention must be low first: the device only starts a read in the data phase
  task automatic start_read;
    wr(gat_pkg::OFF_CTRL, 32'h0);
    @(posedge hclk) read_start <= 1'b1;
    @(posedge hclk) read_start <= 1'b0;
  endtask : start_read
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, read_start, tx_valid, tx_last, srq_req} = '0;
    {sec_en, my_sec, term_char, term_line, term_count, end_char, tx_byte} = '0;
    {num_errors, num_checks, cycles, done_cnt, strobe_cnt, taken_cnt, eoi_cnt} = '0;
    hsize = 3'h2;
    my_addr = 5'h05;
    read_count = 16'h0002;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    st(1'b0, 1'b0);
    rd_chk(8'h10, 32'hffffffff, 32'h0);
    // addressing: own codes, ignored top bit, another talker, unlisten
    xfer(8'h25, 3'h3); st(1'b0, 1'b1);
    xfer(8'hc5, 3'h3); st(1'b1, 1'b1);
    xfer(8'h46, 3'h3); st(1'b0, 1'b1);
    xfer(8'h3f, 3'h3); st(1'b0, 1'b0);
    // end character, with the same value first sent as a command
    term_char <= 1'b1;
    end_char <= 8'h0d;
    xfer(8'h25, 3'h3);
    start_read();
    xfer(8'h0d, 3'h3); chk(done_cnt, 0);
    xfer(8'h41, 3'h1); chk({24'h0, rx_byte}, 32'h41);
    chk(done_cnt, 0);
    xfer(8'h0d, 3'h1); chk(done_cnt, 1);
    // end line
    term_char <= 1'b0;
    term_line <= 1'b1;
    start_read();
    xfer(8'h33, 3'h5); chk(done_cnt, 2);
    chk(strobe_cnt, 3);
    // count of two, end character disabled so only the count ends it
    term_line <= 1'b0;
    term_count <= 1'b1;
    start_read();
    xfer(8'h11, 3'h1); chk(done_cnt, 2);
    xfer(8'h0d, 3'h1); chk(done_cnt, 3);
    chk({31'h0, gat_link_if_inst.hold_dev}, 32'h1);
    // character and count together: the character comes first
    term_char <= 1'b1;
    read_count <= 16'h0005;
    start_read();
    xfer(8'h0d, 3'h1); chk(done_cnt, 4);
    xfer(8'h3f, 3'h3);
    // talker sends its last byte with the end line
    {term_char, term_count, term_line} <= 3'b001;
    xfer(8'h45, 3'h3); st(1'b1, 1'b0);
    wr(gat_pkg::OFF_CTRL, 32'h8);
    {tx_byte, tx_valid, tx_last} <= {8'h5a, 2'b11};
    // drop the byte in the very cycle it is taken, else it would be offered again
    do @(posedge hclk); while (tx_taken !== 1'b1);
    tx_valid <= 1'b0;
    rd_chk(gat_pkg::OFF_STATUS, 32'h2ff, 32'h25a);
    chk(eoi_cnt, 2);
    // untalked device keeps its byte to itself
    xfer(8'h5f, 3'h3); st(1'b0, 1'b0);
    wr(gat_pkg::OFF_CTRL, 32'h8);
    tx_valid <= 1'b1;
    repeat (20) @(posedge hclk);
    chk(taken_cnt, 1);
    tx_valid <= 1'b0;
    rd_chk(gat_pkg::OFF_STATUS, 32'h200, 32'h0);
    // secondary must be the matching code right after the primary
    sec_en <= 1'b1;
    my_sec <= 5'h03;
    xfer(8'h25, 3'h3);
    xfer(8'h64, 3'h3); st(1'b0, 1'b0);
    xfer(8'h25, 3'h3);
    xfer(8'h63, 3'h3); st(1'b0, 1'b1);
    xfer(8'h3f, 3'h3);
    // address bounds: 31 refused, 30 legal
    sec_en <= 1'b0;
    my_addr <= 5'h1f;
    repeat (2) @(posedge hclk);
    chk({31'h0, addr_bad}, 32'h1);
    my_addr <= 5'h1e;
    repeat (2) @(posedge hclk);
    chk({31'h0, addr_bad}, 32'h0);
    xfer(8'h3e, 3'h3); st(1'b0, 1'b1);
    // service request while addressed only as listener
    srq_req <= 1'b1;
    repeat (3) @(posedge hclk);
    rd_chk(gat_pkg::OFF_SRQ, 32'h1, 32'h1);
    end_sim();
  end
endmodule : ieee488_addr_term_logic_tb
`default_nettype wire
